// ### rtl/dsic_top.sv
// Bus slave and output level selection of the dish supply regulator
//
// Contract
// - Bus control off: enable, clock line and select pin choose level.
// - Bus control on: voltage code sets level, pins have no effect.
// - Registers stay readable and writable with bus control off.
// - Register enable bit switches output with bus control on; resets to one.
// - Slave only, 100 and 400 kbps, same protocol for both.
// - Only 7-bit addresses answered; 10-bit and general call ignored.
// - Strap level sets slave address 0x08, 0x09, 0x10 or 0x11.
// - Each received byte acknowledged, data low through next clock high.
// - Written value commits on falling edge of last data bit.
// - First control register at 0x00, resets 0x08, bit 7 bus control.
// - Voltage code in bits 4 to 1, 11 V upward, resets to 13.4 V.
// - Output enable bit is bit 3 of second register at 0x01.
`timescale 1ns/1ps
`default_nettype none
module dsic_top (
  // System clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Serial bus, clock line driven only by the master
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe_n,
  // Level pins
  input wire logic i_enable_pin,
  input wire logic i_level_select_pin,
  // Address strap level, encoded by the front end
  input wire logic [1:0] i_addr_strap,
  // Selected output level
  output dsic_pkg::dsic_level_s o_dish_supply_output
);
  import dsic_pkg::*;

  // Synchronised pins
  logic [5:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic en_s;
  logic sel_s;
  logic [1:0] strap_s;

  // Frame detection
  logic sda_prev;
  logic eng_hold;
  logic starting;
  logic frame_rst;

  // Write crossing
  dsic_wr_s wr_in;
  logic wr_tgl;
  logic wr_tgl_s;
  logic wr_tgl_prev;
  logic link_drv;

  // Registers and strap
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [6:0] slave_addr;
  logic [1:0] strap_cnt;
  dsic_snap_s snap;
  dsic_snap_s snap_s;

  // Decode a pin combination into a voltage code
  function automatic logic [3:0] pin_code(input logic clk_hi,
                                          input logic sel_hi);
    case ({clk_hi, sel_hi})
      2'h3: pin_code = LVL_19V4;
      2'h2: pin_code = LVL_14V6;
      2'h1: pin_code = LVL_18V2;
      default: pin_code = LVL_13V4;
    endcase
  endfunction

  // Map the strap level onto the slave address
  function automatic logic [6:0] strap_addr(input logic [1:0] lvl);
    case (lvl)
      STRAP_VCC: strap_addr = ADDR_VCC;
      STRAP_FLOAT: strap_addr = ADDR_FLOAT;
      STRAP_GND: strap_addr = ADDR_GND;
      default: strap_addr = ADDR_MIDHI;
    endcase
  endfunction

  // All pins cross into the system clock for local use; the link takes the raw bus lines
  dsic_sync #(
    .WIDTH(6)
  ) u_pin_sync (
    .i_clk(i_clk_sys),
    .i_rst(i_rst),
    .i_d({i_scl, i_sda, i_enable_pin, i_level_select_pin, i_addr_strap}),
    .o_q(pins_s)
  );

  assign scl_s = pins_s[5];
  assign sda_s = pins_s[4];
  assign en_s = pins_s[3];
  assign sel_s = pins_s[2];
  assign strap_s = pins_s[1:0];

  // Start and stop seen while the clock line is high
  wire start_det = scl_s && sda_prev && !sda_s;
  wire stop_det = scl_s && !sda_prev && sda_s;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sda_prev <= 1'b1;
    end else begin
      sda_prev <= sda_s;
    end
  end

  // Engine is held between frames; released once the clock line
  // goes low after a start, long before the next rising edge.
  // Holding it avoids counting start and stop edges as data bits.
  wire next_starting = start_det || (starting && scl_s);
  wire next_hold = stop_det || start_det || (eng_hold && !(starting && !scl_s));

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      eng_hold <= 1'b1;
      starting <= 1'b0;
    end else begin
      eng_hold <= next_hold;
      starting <= next_starting;
    end
  end

  assign frame_rst = i_rst || eng_hold;

  // Control registers only change by bus writes and reset, the status bits by those writes and the enable pin, so the
  // link may sample them through a plain level synchroniser
  dsic_sync #(
    .WIDTH($bits(dsic_snap_s))
  ) u_snap_sync (
    .i_clk(i_scl),
    .i_rst(i_rst),
    .i_d(snap),
    .o_q(snap_s)
  );

  // Byte engine in the bus clock domain
  dsic_link u_link (
    .i_scl(i_scl),
    .i_rst(i_rst),
    .i_frame_rst(frame_rst),
    .i_sda(i_sda),
    .o_sda_drv(link_drv),
    .i_snap(snap_s),
    .o_wr(wr_in),
    .o_wr_toggle(wr_tgl)
  );

  // Open-drain data line: output held low, enable active low
  assign o_sda_o = 1'b0;
  assign o_sda_oe_n = ~link_drv;

  // Write event crosses as a toggle; the word is stable by then
  dsic_sync #(
    .WIDTH(1)
  ) u_wr_sync (
    .i_clk(i_clk_sys),
    .i_rst(i_rst),
    .i_d(wr_tgl),
    .o_q(wr_tgl_s)
  );

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_tgl_prev <= 1'b0;
    end else begin
      wr_tgl_prev <= wr_tgl_s;
    end
  end

  wire wr_pulse = wr_tgl_s ^ wr_tgl_prev;

  // Register write decode; status is read only, bus mode ignored
  wire wr_c1 = wr_pulse && (wr_in.addr == REG_CTRL1);
  wire wr_c2 = wr_pulse && (wr_in.addr == REG_CTRL2);
  wire [7:0] next_ctrl1 = wr_c1 ? wr_in.data : ctrl1;
  wire [7:0] next_ctrl2 = wr_c2 ? wr_in.data : ctrl2;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctrl1 <= CTRL1_RST;
      ctrl2 <= CTRL2_RST;
    end else begin
      ctrl1 <= next_ctrl1;
      ctrl2 <= next_ctrl2;
    end
  end

  // Strap caught once after reset, when the synchroniser has filled
  wire strap_cap = (strap_cnt == STRAP_WAIT - 2'h1);
  wire [1:0] next_strap_cnt = (strap_cnt == STRAP_WAIT) ? strap_cnt :
                              strap_cnt + 2'h1;
  wire [6:0] next_addr = strap_cap ? strap_addr(strap_s) : slave_addr;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      strap_cnt <= 2'h0;
      slave_addr <= ADDR_VCC;
    end else begin
      strap_cnt <= next_strap_cnt;
      slave_addr <= next_addr;
    end
  end

  // Mode select and fields
  wire bus_ctl = ctrl1[BUSCTL_BIT];
  wire [3:0] vcode = ctrl1[VCODE_MSB:VCODE_LSB];
  wire out_en = ctrl2[OUTEN_BIT];

  // Pin mode follows the synchronised clock line, so bus traffic moves it
  dsic_level_s next_level;
  assign next_level.on = bus_ctl ? out_en : en_s;
  assign next_level.code = bus_ctl ? vcode : pin_code(scl_s, sel_s);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_dish_supply_output <= '{on: 1'b0, code: LVL_RST};
    end else begin
      o_dish_supply_output <= next_level;
    end
  end

  // Status byte shows the live output state and the mode
  wire [7:0] stat = {6'h00, bus_ctl, o_dish_supply_output.on};
  assign snap = '{addr: slave_addr, ctrl1: ctrl1, ctrl2: ctrl2,
                  stat: stat};

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  a_pin_level_top: assert property (
    (!bus_ctl && en_s && scl_s && sel_s) |=>
      o_dish_supply_output.on && o_dish_supply_output.code == LVL_19V4)
    else $error("pin mode high combination not 19.4 V");

  a_pin_level_low: assert property (
    (!bus_ctl && en_s && !scl_s && !sel_s) |=>
      o_dish_supply_output.code == LVL_13V4)
    else $error("pin mode low combination not 13.4 V");

  a_pin_level_mid: assert property (
    (!bus_ctl && en_s && scl_s && !sel_s) |=>
      o_dish_supply_output.code == LVL_14V6)
    else $error("pin mode clock high select low not 14.6 V");

  a_pin_level_sel: assert property (
    (!bus_ctl && en_s && !scl_s && sel_s) |=>
      o_dish_supply_output.code == LVL_18V2)
    else $error("pin mode clock low select high not 18.2 V");

  a_pin_enable_off: assert property (
    (!bus_ctl && !en_s) |=> !o_dish_supply_output.on)
    else $error("output on with enable pin low in pin mode");

  a_reg_code_follow: assert property (
    bus_ctl |=> o_dish_supply_output.code == $past(vcode))
    else $error("register mode level differs from voltage code");

  a_reg_output_on: assert property (
    bus_ctl |=> o_dish_supply_output.on == $past(out_en))
    else $error("register mode enable differs from enable bit");

  a_reg_enable_bit: assert property (
    (bus_ctl && !out_en && $changed(en_s)) |=>
      !o_dish_supply_output.on)
    else $error("enable pin leaked through in register mode");

  a_write_commit: assert property (
    wr_c1 |=> ctrl1 == $past(wr_in.data))
    else $error("write to first register not committed");

  a_write_ctrl2: assert property (
    wr_c2 |=> ctrl2 == $past(wr_in.data))
    else $error("write to second register not committed");

  a_unmapped_ignored: assert property (
    (wr_pulse && wr_in.addr > REG_STAT) |=>
      $stable(ctrl1) && $stable(ctrl2))
    else $error("unmapped write altered a control register");

  a_status_readonly: assert property (
    (wr_pulse && wr_in.addr == REG_STAT) |=>
      $stable(ctrl1) && $stable(ctrl2))
    else $error("status write altered a control register");

  a_stop_holds: assert property (
    stop_det |=> eng_hold [*2])
    else $error("engine not held after stop");

  a_strap_gnd: assert property (
    (strap_cap && strap_s == STRAP_GND) |=> slave_addr == ADDR_GND)
    else $error("ground strap did not select its address");

  c_write_ctrl1: cover property (wr_pulse && wr_in.addr == REG_CTRL1);
  c_bus_mode_on: cover property (bus_ctl && o_dish_supply_output.on);
  c_frame_start: cover property (start_det ##[1:200] !eng_hold);
endmodule
`default_nettype wire

// ### rtl/dsic_pkg.sv
// Shared constants and types for the dish supply bus control block
package dsic_pkg;

  // Register offsets
  localparam logic [7:0] REG_CTRL1 = 8'h00;
  localparam logic [7:0] REG_CTRL2 = 8'h01;
  localparam logic [7:0] REG_STAT = 8'h02;

  // Reset values
  localparam logic [7:0] CTRL1_RST = 8'h08;
  localparam logic [7:0] CTRL2_RST = 8'h09;
  localparam logic [3:0] LVL_RST = 4'h4;

  // Field positions
  localparam int BUSCTL_BIT = 7;
  localparam int VCODE_MSB = 4;
  localparam int VCODE_LSB = 1;
  localparam int OUTEN_BIT = 3;

  // Voltage codes, 11 V at zero, 0.6 V per step
  localparam logic [3:0] LVL_13V4 = 4'h4;
  localparam logic [3:0] LVL_14V6 = 4'h6;
  localparam logic [3:0] LVL_18V2 = 4'hc;
  localparam logic [3:0] LVL_19V4 = 4'he;

  // Slave address for each strap level
  localparam logic [6:0] ADDR_VCC = 7'h08;
  localparam logic [6:0] ADDR_FLOAT = 7'h09;
  localparam logic [6:0] ADDR_GND = 7'h10;
  localparam logic [6:0] ADDR_MIDHI = 7'h11;

  // Strap level encodings from the analog front end
  localparam logic [1:0] STRAP_VCC = 2'h0;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;
  localparam logic [1:0] STRAP_GND = 2'h2;

  // Bit counter positions within a nine-clock byte slot
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // System cycles before the strap synchroniser is trusted
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // Link byte states
  typedef enum logic [4:0] {
    ST_ADDR = 5'h01,
    ST_REG = 5'h02,
    ST_WDATA = 5'h04,
    ST_RDATA = 5'h08,
    ST_IGNORE = 5'h10
  } dsic_state_e;

  // Selected output level
  typedef struct packed {
    logic on;
    logic [3:0] code;
  } dsic_level_s;

  // One register write from the link
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } dsic_wr_s;

  // Quasi-static state the link reads
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] stat;
  } dsic_snap_s;

endpackage

// ### rtl/dsic_sync.sv
// Two-flop synchroniser for levels
`timescale 1ns/1ps
`default_nettype none
module dsic_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Data
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  import dsic_pkg::*;

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule
`default_nettype wire

// ### rtl/dsic_link.sv
// Byte engine of the serial bus slave, clocked by the bus clock
`timescale 1ns/1ps
`default_nettype none
module dsic_link (
  // Bus clock domain
  input wire logic i_scl,
  input wire logic i_rst,
  input wire logic i_frame_rst,
  // Data line
  input wire logic i_sda,
  output logic o_sda_drv,
  // Register side
  input wire dsic_pkg::dsic_snap_s i_snap,
  output dsic_pkg::dsic_wr_s o_wr,
  output logic o_wr_toggle
);
  import dsic_pkg::*;

  dsic_state_e st;
  dsic_state_e next_st;
  logic [3:0] cnt;
  logic [7:0] shift;
  logic [7:0] ptr;
  logic rw;
  logic ack_pend;

  // Byte decode
  wire [7:0] rx_byte = {shift[6:0], i_sda};
  wire last_bit = (cnt == BIT_LAST);
  wire ack_bit = (cnt == BIT_ACK);
  wire addr_hit = (rx_byte[7:1] == i_snap.addr);
  wire ack_byte = (st == ST_ADDR) ? addr_hit :
                  (st == ST_REG) || (st == ST_WDATA);
  wire next_ack = last_bit && ack_byte;
  wire next_rw = (st == ST_ADDR && last_bit) ? i_sda : rw;
  wire [3:0] next_cnt = ack_bit ? 4'h0 : cnt + 4'h1;
  wire master_ack = (st == ST_RDATA) && ack_bit && !i_sda;
  wire bump = ((st == ST_WDATA) && ack_bit) || master_ack;
  wire [7:0] next_ptr = (st == ST_REG && last_bit) ? rx_byte :
                        bump ? ptr + 8'h01 : ptr;
  wire wr_take = (st == ST_WDATA) && last_bit;
  wire [7:0] rd_byte = (ptr == REG_CTRL1) ? i_snap.ctrl1 :
                       (ptr == REG_CTRL2) ? i_snap.ctrl2 :
                       (ptr == REG_STAT) ? i_snap.stat : 8'h00;
  wire [2:0] tx_idx = 3'h7 - cnt[2:0];
  wire tx_low = (st == ST_RDATA) && !ack_bit && !rd_byte[tx_idx];
  wire next_drv = (ack_bit && ack_pend) || tx_low;
  wire next_tgl = o_wr_toggle ^ ((st == ST_WDATA) && ack_bit && ack_pend);

  // Byte sequencing; only 7-bit addressing, no general call
  always_comb begin
    next_st = st;
    if (last_bit && st == ST_ADDR && !addr_hit) begin
      next_st = ST_IGNORE;
    end else if (ack_bit) begin
      case (st)
        ST_ADDR: next_st = rw ? ST_RDATA : ST_REG;
        ST_REG: next_st = ST_WDATA;
        ST_RDATA: next_st = i_sda ? ST_IGNORE : ST_RDATA;
        ST_WDATA: next_st = ST_WDATA;
        ST_IGNORE: next_st = ST_IGNORE;
        default: next_st = ST_IGNORE;
      endcase
    end
  end

  // Frame state, cleared by every start and stop
  always_ff @(posedge i_scl or posedge i_frame_rst) begin
    if (i_frame_rst) begin
      st <= ST_ADDR;
      cnt <= 4'h0;
      shift <= 8'h00;
      rw <= 1'b0;
      ack_pend <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      shift <= rx_byte;
      rw <= next_rw;
      ack_pend <= next_ack;
    end
  end

  // Pointer survives a repeated start for register reads
  always_ff @(posedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      ptr <= 8'h00;
      o_wr <= '0;
    end else begin
      ptr <= next_ptr;
      o_wr <= wr_take ? {ptr, rx_byte} : o_wr;
    end
  end

  // Data line changes only while the clock is low
  always_ff @(negedge i_scl or posedge i_frame_rst) begin
    if (i_frame_rst) begin
      o_sda_drv <= 1'b0;
    end else begin
      o_sda_drv <= next_drv;
    end
  end

  // Commit event on the falling edge ending the last data bit
  always_ff @(negedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      o_wr_toggle <= 1'b0;
    end else begin
      o_wr_toggle <= next_tgl;
    end
  end

  a_ack_held_low: assert property (
    @(posedge i_scl) disable iff (i_frame_rst)
    (ack_bit && ack_pend) |-> o_sda_drv)
    else $error("acknowledge not driven during ninth clock");

  a_foreign_addr_ignored: assert property (
    @(posedge i_scl) disable iff (i_frame_rst)
    (st == ST_ADDR && last_bit && !addr_hit) |=> st == ST_IGNORE
      ##1 !ack_pend)
    else $error("foreign address not ignored");

  c_read_data: cover property (
    @(posedge i_scl) disable iff (i_frame_rst)
    st == ST_RDATA && ack_bit && !i_sda);
endmodule
`default_nettype wire

// ### dv/dsic_bus_master.sv
// Serial bus master model that drives the clock and data lines
`timescale 1ns/1ps
`default_nettype none
module dsic_bus_master (
  // Pacing clock
  input wire logic i_clk_sys,
  // Resolved data line
  input wire logic i_sda,
  // Open-drain drives, high means released to the pull-up
  output logic o_scl,
  output logic o_sda_rel
);
  int q = 25; // Quarter bit in system cycles; 25 gives 400 kbps
  logic ack_ok;
  logic [7:0] rx;

  // Both lines idle high through the pull-ups
  initial begin
    o_scl = 1'b1;
    o_sda_rel = 1'b1;
    ack_ok = 1'b0;
    rx = 8'h00;
  end

  // Wait a number of system cycles
  task automatic wq(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask

  // Pin-mode stimulus: hold the clock line outside frames
  task automatic hold_scl(input logic v);
    o_scl <= v;
  endtask

  // Start or repeated start; leaves the clock low
  task automatic start();
    o_sda_rel <= 1'b1;
    wq(q);
    o_scl <= 1'b1;
    wq(q);
    o_sda_rel <= 1'b0;
    wq(q);
    o_scl <= 1'b0;
    wq(q);
  endtask

  // Stop: data rises while the clock is high
  task automatic stop();
    o_sda_rel <= 1'b0;
    wq(q);
    o_scl <= 1'b1;
    wq(q);
    o_sda_rel <= 1'b1;
    wq(q);
  endtask

  // Byte out MSB first, then the ninth clock; ack must stay low all high
  task automatic byte_out(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      o_sda_rel <= b[i];
      wq(q);
      o_scl <= 1'b1;
      wq(2 * q);
      o_scl <= 1'b0;
      wq(q);
    end
    o_sda_rel <= 1'b1;
    wq(q);
    o_scl <= 1'b1;
    wq(1);
    ack_ok = !i_sda;
    wq(2 * q - 2);
    ack_ok = ack_ok & !i_sda;
    wq(1);
    o_scl <= 1'b0;
    wq(q);
  endtask

  // Byte in, sampled mid-high, then a not-acknowledge to end the read
  task automatic byte_in_nack();
    o_sda_rel <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      wq(q);
      o_scl <= 1'b1;
      wq(q);
      rx[i] = i_sda;
      wq(q);
      o_scl <= 1'b0;
      wq(q);
    end
    wq(q); // Released data line is the not-acknowledge
    o_scl <= 1'b1;
    wq(2 * q);
    o_scl <= 1'b0;
    wq(q);
  endtask
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the dish supply bus control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dsic_pkg::*;
  logic i_clk_sys, rst, en_pin, sel_pin;
  logic [1:0] strap;
  logic [7:0] rd;
  wire scl, sda_rel, sda_o, sda_oe_n, sda;
  dsic_level_s lvl;
  int err_count = 0;
  int num_checks = 0;
  logic [3:0] pin_code [4] = '{LVL_19V4, LVL_14V6, LVL_18V2, LVL_13V4};
  logic [6:0] addr_tab [4] = '{ADDR_VCC, ADDR_FLOAT, ADDR_GND, ADDR_MIDHI};

  // Open-drain data line with pull-up
  assign sda = sda_rel & (sda_oe_n | sda_o);

  dsic_top dsic_top_i (
    .i_clk_sys(i_clk_sys), .i_rst(rst), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n), .i_enable_pin(en_pin),
    .i_level_select_pin(sel_pin), .i_addr_strap(strap),
    .o_dish_supply_output(lvl)
  );

  dsic_bus_master dsic_bus_master_i (
    .i_clk_sys(i_clk_sys), .i_sda(sda), .o_scl(scl), .o_sda_rel(sda_rel)
  );

  // 40 MHz system clock
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Reset held three cycles, then settle
  task automatic do_reset();
    rst <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    rst <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
  endtask

  // Acknowledge result of the last byte sent
  task automatic acked(input logic exp);
    check({7'h00, dsic_bus_master_i.ack_ok}, {7'h00, exp});
  endtask

  task automatic wr_reg(input logic [6:0] dev, input logic [7:0] a,
                        input logic [7:0] d);
    dsic_bus_master_i.start();
    dsic_bus_master_i.byte_out({dev, 1'b0});
    acked(1'b1);
    dsic_bus_master_i.byte_out(a);
    acked(1'b1);
    dsic_bus_master_i.byte_out(d);
    acked(1'b1);
    dsic_bus_master_i.stop();
    repeat (6) @(posedge i_clk_sys);
  endtask

  task automatic rd_reg(input logic [6:0] dev, input logic [7:0] a);
    dsic_bus_master_i.start();
    dsic_bus_master_i.byte_out({dev, 1'b0});
    acked(1'b1);
    dsic_bus_master_i.byte_out(a);
    acked(1'b1);
    dsic_bus_master_i.start();
    dsic_bus_master_i.byte_out({dev, 1'b1});
    acked(1'b1);
    dsic_bus_master_i.byte_in_nack();
    rd = dsic_bus_master_i.rx;
    dsic_bus_master_i.stop();
  endtask

  // Header that must go unanswered
  task automatic probe(input logic [7:0] hdr);
    dsic_bus_master_i.start();
    dsic_bus_master_i.byte_out(hdr);
    acked(1'b0);
    dsic_bus_master_i.stop();
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    en_pin = 1'b1;
    sel_pin = 1'b1;
    strap = STRAP_VCC;
    do_reset();
    // Pin mode: clock line level also moves the output
    for (int i = 0; i < 4; i++) begin
      sel_pin <= !i[0];
      dsic_bus_master_i.hold_scl(!i[1]);
      repeat (6) @(posedge i_clk_sys);
      check({3'h0, lvl}, {3'h0, 1'b1, pin_code[i]});
    end
    en_pin <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    check({7'h00, lvl.on}, 8'h00);
    dsic_bus_master_i.hold_scl(1'b1);
    en_pin <= 1'b1;
    sel_pin <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    // Reset values, registers usable with bus control off
    rd_reg(ADDR_VCC, REG_CTRL1);
    check(rd, 8'h08);
    rd_reg(ADDR_VCC, REG_CTRL2);
    check(rd, 8'h09);
    wr_reg(ADDR_VCC, REG_CTRL1, 8'h06);
    rd_reg(ADDR_VCC, REG_CTRL1);
    check(rd, 8'h06);
    check({3'h0, lvl}, {3'h0, 1'b1, LVL_14V6});
    wr_reg(ADDR_VCC, 8'h05, 8'hff);
    rd_reg(ADDR_VCC, 8'h05);
    check(rd, 8'h00);
    // Bus control on: code sets level, pins ignored
    wr_reg(ADDR_VCC, REG_CTRL1, 8'h9e);
    check({3'h0, lvl}, {3'h0, 1'b1, 4'hf});
    en_pin <= 1'b0;
    sel_pin <= 1'b1;
    dsic_bus_master_i.hold_scl(1'b0);
    repeat (8) @(posedge i_clk_sys);
    check({3'h0, lvl}, {3'h0, 1'b1, 4'hf});
    dsic_bus_master_i.hold_scl(1'b1);
    en_pin <= 1'b1;
    wr_reg(ADDR_VCC, REG_CTRL2, 8'h01);
    check({7'h00, lvl.on}, 8'h00);
    en_pin <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    en_pin <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    check({7'h00, lvl.on}, 8'h00);
    rd_reg(ADDR_VCC, REG_CTRL2);
    check(rd, 8'h01);
    wr_reg(ADDR_VCC, REG_CTRL2, 8'h09);
    check({7'h00, lvl.on}, 8'h01);
    // Status ignores writes, shows bus control and output on
    wr_reg(ADDR_VCC, REG_STAT, 8'h00);
    rd_reg(ADDR_VCC, REG_STAT);
    check(rd, 8'h03);
    // Standard-mode rate, same protocol
    dsic_bus_master_i.q = 100;
    wr_reg(ADDR_VCC, REG_CTRL1, 8'h88);
    check({3'h0, lvl}, {3'h0, 1'b1, LVL_13V4});
    dsic_bus_master_i.q = 25;
    // General call, ten-bit header, foreign address
    probe(8'h00);
    probe(8'hf0);
    probe({ADDR_FLOAT, 1'b0});
    // Each strap level answers its own address
    for (int s = 0; s < 4; s++) begin
      strap <= s[1:0];
      do_reset();
      rd_reg(addr_tab[s], REG_CTRL1);
      check(rd, CTRL1_RST);
    end
    complete_run();
  end

  // Watchdog sized about a quarter above the expected run
  initial begin
    repeat (90000) @(posedge i_clk_sys);
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
